// >>> hdl/pitb_pkg.sv
// Constants, register map and carrier types for the interrupt and time-base block.
// Assumes a 100 MHz system clock and an Avalon-MM master with 32-bit data.
package pitb_pkg;
   // Number of request sources
   localparam int NUM_SRC = 14;
   // Source indices, lowest index wins when several are pending
   localparam logic [3:0] SRC_TICK0 = 4'h0;
   localparam logic [3:0] SRC_TOUCH = 4'h1;
   localparam logic [3:0] SRC_CTM_P = 4'h2;
   localparam logic [3:0] SRC_CTM_A = 4'h3;
   localparam logic [3:0] SRC_PTM1_P = 4'h4;
   localparam logic [3:0] SRC_PTM1_A = 4'h5;
   localparam logic [3:0] SRC_SPORT = 4'h6;
   localparam logic [3:0] SRC_EEPROM = 4'h7;
   localparam logic [3:0] SRC_SIFACE = 4'h8;
   localparam logic [3:0] SRC_TICK1 = 4'h9;
   localparam logic [3:0] SRC_PTM2_P = 4'hA;
   localparam logic [3:0] SRC_PTM2_A = 4'hB;
   localparam logic [3:0] SRC_CONV = 4'hC;
   localparam logic [3:0] SRC_LOWSUP = 4'hD;
   // Register byte offsets
   localparam logic [4:0] OFS_CLK_SEL = 5'h00;
   localparam logic [4:0] OFS_TICK_CTRL = 5'h04;
   localparam logic [4:0] OFS_FLAGS = 5'h08;
   localparam logic [4:0] OFS_ENABLES = 5'h0C;
   localparam logic [4:0] OFS_GLOBAL = 5'h10;
   localparam logic [4:0] OFS_STATUS = 5'h14;
   // Field positions
   localparam int CS_T0_LSB = 0;
   localparam int CS_T1_LSB = 4;
   localparam int TC_T0_PER_LSB = 0;
   localparam int TC_T0_ON = 3;
   localparam int TC_T1_PER_LSB = 4;
   localparam int TC_T1_ON = 7;
   localparam int GLB_EN_BIT = 0;
   localparam int ST_REQ_BIT = 8;
   // Implemented bits of the clock-select register
   localparam logic [7:0] CS_MASK = 8'h33;
   // Reset values
   localparam logic [7:0] CLK_SEL_RST = 8'h00;
   localparam logic [7:0] TICK_CTRL_RST = 8'h00;
   localparam logic [NUM_SRC-1:0] SRC_RST = 14'h0000;
   // Prescaler source codes
   localparam logic [1:0] PSRC_SYS = 2'h0;
   localparam logic [1:0] PSRC_SYS_DIV4 = 2'h1;
   localparam logic [1:0] PSRC_SUB = 2'h2;
   localparam logic [1:0] PSRC_HS = 2'h3;
   // Prescaler width and shortest period (2^8)
   localparam int PRESC_W = 15;
   localparam logic [PRESC_W-1:0] PERIOD_BASE = 15'h0100;
   localparam logic [PRESC_W-1:0] PRESC_ONE = 15'h0001;
   localparam logic [1:0] DIV4_TOP = 2'h3;
   // Synchronised pin indices
   localparam int PIN_LOWSUP = 0;
   localparam int PIN_SUB = 1;
   localparam int PIN_HS = 2;
   localparam int NUM_PIN = 3;
   // Configuration of one time base
   typedef struct packed {
      logic on;
      logic [2:0] period;
      logic [1:0] src;
   } pitb_tick_cfg_t;
   // Bus answer states, one-hot
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK = 2'b10
   } pitb_bus_state_t;
endpackage

// >>> hdl/pitb_top.sv
// Peripheral request flags, enables, vectoring and two periodic time bases.
// Assumes peripheral events are one-cycle pulses on clk_sys_i; low-supply, sub
// and high-speed clock inputs are asynchronous and are synchronised here.
// Behaviour
// RULE_01 - conversion done sets its request flag
// RULE_02 - vector only with global, own enable, stack free
// RULE_03 - service clears own flag and global enable
// RULE_04 - time-base overflow sets its request flag
// RULE_05 - fifteen-bit prescaler, four selectable clock sources
// RULE_06 - clock-select fields at bits 5:4, 1:0
// RULE_07 - time-base on bits 7 and 3
// RULE_08 - period select gives 2^8 to 2^15
// RULE_09 - two comparator requests per timer, own flags
// RULE_10 - comparator flag cleared on service
// RULE_11 - EEPROM write end sets flag, service clears
// RULE_12 - low supply sets flag, service clears
// RULE_13 - touch slot overflow sets flag, service clears
// RULE_14 - serial interface byte, match, timeout set flag
// RULE_15 - six serial port conditions form low pulse
// RULE_16 - service clears only combined serial port flag
// RULE_17 - any flag rising wakes the device
// RULE_18 - pin and low supply flags wake too
// RULE_19 - software presets flag to block a wake
// RULE_20 - flag stays set until serviced or cleared
// RULE_21 - return from interrupt sets global enable
// RULE_22 - no acknowledge while return stack full
// RULE_23 - fixed priority picks one pending request
// RULE_24 - running time base wraps every period
//
// Our own choices: the address map and the Avalon-MM slave port.
module pitb_top
   import pitb_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic conv_done_i,
   input wire logic [1:0] compact_timer_match_i,
   input wire logic [3:0] periodic_timer_match_i,
   input wire logic eeprom_write_done_i,
   input wire logic touch_slot_ovf_i,
   input wire logic [3:0] serial_iface_evt_i,
   input wire logic [5:0] serial_port_cond_i,
   input wire logic low_supply_async_i,
   input wire logic sub_clk_i,
   input wire logic hs_clk_i,
   input wire logic stack_full_i,
   input wire logic irq_ack_i,
   input wire logic return_from_irq_i,
   output logic irq_req_o,
   output logic [3:0] irq_vector_o,
   output logic wake_o
);
   // Shortest tick period in system clocks, used by a check below
   localparam int FAST_PERIOD = 256;

   // Pin synchroniser chain and filtered levels
   logic [NUM_PIN-1:0] pin_raw;
   logic [NUM_PIN-1:0] sync1;
   logic [NUM_PIN-1:0] sync2;
   logic [NUM_PIN-1:0] sync3;
   logic [NUM_PIN-1:0] pin_lvl;
   logic [NUM_PIN-1:0] pin_lvl_d;
   logic [NUM_PIN-1:0] next_pin_lvl;
   logic [NUM_PIN-1:0] pin_rise;
   // Divide-by-four strobe
   logic [1:0] div4_cnt;
   logic [1:0] next_div4_cnt;
   logic div4_tick;
   // Software registers
   logic [7:0] clk_sel;
   logic [7:0] next_clk_sel;
   logic [7:0] tick_ctrl;
   logic [7:0] next_tick_ctrl;
   logic [NUM_SRC-1:0] enables;
   logic [NUM_SRC-1:0] next_enables;
   logic glob_en;
   logic next_glob_en;
   // Request flags and their previous value
   logic [NUM_SRC-1:0] flags;
   logic [NUM_SRC-1:0] next_flags;
   logic [NUM_SRC-1:0] flags_d;
   logic [NUM_SRC-1:0] set_vec;
   logic [NUM_SRC-1:0] clr_vec;
   logic [NUM_SRC-1:0] pending;
   logic [NUM_SRC-1:0] wmask;
   // Serial port condition edges
   logic [5:0] sport_cond_d;
   logic sport_req_n;
   // Core handshake
   logic next_irq_req;
   logic [3:0] next_vector;
   logic next_wake;
   // Time bases
   pitb_tick_cfg_t tick_cfg [2];
   logic [1:0] tick_ovf;
   // Bus slave
   pitb_bus_state_t bus_state;
   pitb_bus_state_t next_bus_state;
   logic [31:0] next_readdata;
   logic bus_req;
   logic wr_fire;

   assign pin_raw[PIN_LOWSUP] = low_supply_async_i;
   assign pin_raw[PIN_SUB] = sub_clk_i;
   assign pin_raw[PIN_HS] = hs_clk_i;

   // Filtered level follows only when stages two and three agree
   always_comb begin
      for (int p = 0; p < NUM_PIN; p++) begin
         next_pin_lvl[p] = (sync2[p] == sync3[p]) ? sync3[p] : pin_lvl[p];
      end
   end

   // Three-stage synchroniser and filtered level
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
         pin_lvl <= '0;
         pin_lvl_d <= '0;
      end else begin
         sync1 <= pin_raw;
         sync2 <= sync1;
         sync3 <= sync2;
         pin_lvl <= next_pin_lvl;
         pin_lvl_d <= pin_lvl;
      end
   end

   // Rising edges of filtered pins
   assign pin_rise = pin_lvl & ~pin_lvl_d;

   // System clock divided by four
   always_comb begin
      next_div4_cnt = 2'(div4_cnt + 2'h1);
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         div4_cnt <= 2'h0;
      end else begin
         div4_cnt <= next_div4_cnt;
      end
   end

   assign div4_tick = (div4_cnt == DIV4_TOP);

   // Unpack time-base configuration from the two registers
   always_comb begin
      tick_cfg[0].on = tick_ctrl[TC_T0_ON]; // see RULE_07
      tick_cfg[0].period = tick_ctrl[TC_T0_PER_LSB +: 3]; // see RULE_08
      tick_cfg[0].src = clk_sel[CS_T0_LSB +: 2]; // see RULE_06
      tick_cfg[1].on = tick_ctrl[TC_T1_ON]; // see RULE_07
      tick_cfg[1].period = tick_ctrl[TC_T1_PER_LSB +: 3]; // see RULE_08
      tick_cfg[1].src = clk_sel[CS_T1_LSB +: 2]; // see RULE_06
   end

   // Two independent time bases
   for (genvar t = 0; t < 2; t++) begin : g_tick
      logic [PRESC_W-1:0] cnt; // Prescaler count
      logic [PRESC_W-1:0] next_cnt;
      logic [PRESC_W-1:0] mask; // Period minus one
      logic adv; // Prescaler clock strobe
      logic ovf;

      // Source select, period mask and wrap
      always_comb begin
         unique case (tick_cfg[t].src) // see RULE_05
            PSRC_SYS: adv = 1'b1;
            PSRC_SYS_DIV4: adv = div4_tick;
            PSRC_SUB: adv = pin_rise[PIN_SUB];
            PSRC_HS: adv = pin_rise[PIN_HS];
         endcase
         // Shift past bit 14 leaves zero, so code 7 gives all ones
         mask = PRESC_W'((PERIOD_BASE << tick_cfg[t].period) - PRESC_ONE); // see RULE_08
         ovf = tick_cfg[t].on && adv && ((cnt & mask) == mask); // see RULE_04
         if (!tick_cfg[t].on) begin
            next_cnt = '0; // see RULE_07
         end else if (ovf) begin
            next_cnt = '0; // see RULE_24
         end else if (adv) begin
            next_cnt = PRESC_W'(cnt + PRESC_ONE);
         end else begin
            next_cnt = cnt;
         end
      end

      always_ff @(posedge clk_sys_i) begin
         if (rst_i) begin
            cnt <= '0;
         end else begin
            cnt <= next_cnt;
         end
      end

      assign tick_ovf[t] = ovf;
   end

   // Serial port: a new condition gives an active-low request pulse
   assign sport_req_n = ~|(serial_port_cond_i & ~sport_cond_d); // see RULE_15

   // Hardware set sources
   always_comb begin
      set_vec = '0;
      set_vec[SRC_TICK0] = tick_ovf[0]; // see RULE_04
      set_vec[SRC_TICK1] = tick_ovf[1]; // see RULE_04
      set_vec[SRC_TOUCH] = touch_slot_ovf_i; // see RULE_13
      set_vec[SRC_CTM_P] = compact_timer_match_i[0]; // see RULE_09
      set_vec[SRC_CTM_A] = compact_timer_match_i[1]; // see RULE_09
      set_vec[SRC_PTM1_P] = periodic_timer_match_i[0];
      set_vec[SRC_PTM1_A] = periodic_timer_match_i[1];
      set_vec[SRC_PTM2_P] = periodic_timer_match_i[2];
      set_vec[SRC_PTM2_A] = periodic_timer_match_i[3];
      set_vec[SRC_SPORT] = ~sport_req_n; // see RULE_15
      set_vec[SRC_EEPROM] = eeprom_write_done_i; // see RULE_11
      set_vec[SRC_SIFACE] = |serial_iface_evt_i; // see RULE_14
      set_vec[SRC_CONV] = conv_done_i; // see RULE_01
      set_vec[SRC_LOWSUP] = pin_rise[PIN_LOWSUP]; // see RULE_12, RULE_18
   end

   // Bus handshake: one wait cycle, then the access takes effect
   assign bus_req = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = bus_req && (bus_state == BUS_IDLE);
   assign wr_fire = avs_write_i && (bus_state == BUS_ACK);

   // Byte lanes for the 14-bit flag and enable words
   assign wmask = {{(NUM_SRC - 8){avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

   // Service clears only the vectored source
   always_comb begin
      clr_vec = '0;
      if (irq_ack_i) begin
         clr_vec[irq_vector_o] = 1'b1; // see RULE_03, RULE_10, RULE_16
      end
   end

   // Flag, enable and configuration next values
   always_comb begin
      next_flags = flags;
      next_enables = enables;
      next_clk_sel = clk_sel;
      next_tick_ctrl = tick_ctrl;
      next_glob_en = glob_en;
      if (wr_fire) begin
         unique case (avs_address_i)
            OFS_CLK_SEL: begin
               if (avs_byteenable_i[0]) begin
                  next_clk_sel = avs_writedata_i[7:0] & CS_MASK; // see RULE_06
               end
            end
            OFS_TICK_CTRL: begin
               if (avs_byteenable_i[0]) begin
                  next_tick_ctrl = avs_writedata_i[7:0]; // see RULE_07
               end
            end
            OFS_FLAGS: begin
               // Software may set a flag to block its wake
               next_flags = (flags & ~wmask) | (avs_writedata_i[NUM_SRC-1:0] & wmask);
            end
            OFS_ENABLES: begin
               next_enables = (enables & ~wmask) | (avs_writedata_i[NUM_SRC-1:0] & wmask);
            end
            OFS_GLOBAL: begin
               if (avs_byteenable_i[0]) begin
                  next_glob_en = avs_writedata_i[GLB_EN_BIT];
               end
            end
            default: begin
               // Unmapped or read-only: write ignored
            end
         endcase
      end
      // Flags hold until serviced or written; a set in the same cycle wins
      next_flags = (next_flags & ~clr_vec) | set_vec; // see RULE_20
      // Service blocks nesting, return from interrupt reopens
      if (irq_ack_i) begin
         next_glob_en = 1'b0; // see RULE_03
      end
      if (return_from_irq_i) begin
         next_glob_en = 1'b1; // see RULE_21
      end
   end

   // Pending requests and priority pick
   assign pending = flags & enables;

   always_comb begin
      next_vector = irq_vector_o;
      for (int s = NUM_SRC - 1; s >= 0; s--) begin
         if (pending[s]) begin
            next_vector = 4'(s); // see RULE_23
         end
      end
      // Drop the request in the acknowledge cycle so it is not taken twice
      next_irq_req = glob_en && !stack_full_i && (|pending) && !irq_ack_i; // see RULE_02, RULE_22
      // Wake on any flag rising, enables ignored
      next_wake = |(flags & ~flags_d); // see RULE_17, RULE_18
   end

   // Register state
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         flags <= SRC_RST;
         flags_d <= SRC_RST;
         enables <= SRC_RST;
         clk_sel <= CLK_SEL_RST;
         tick_ctrl <= TICK_CTRL_RST;
         glob_en <= 1'b0;
         sport_cond_d <= '0;
         irq_req_o <= 1'b0;
         irq_vector_o <= SRC_TICK0;
         wake_o <= 1'b0;
      end else begin
         flags <= next_flags;
         flags_d <= flags;
         enables <= next_enables;
         clk_sel <= next_clk_sel;
         tick_ctrl <= next_tick_ctrl;
         glob_en <= next_glob_en;
         sport_cond_d <= serial_port_cond_i;
         irq_req_o <= next_irq_req;
         irq_vector_o <= next_vector;
         wake_o <= next_wake;
      end
   end

   // Read mux, sampled in the wait cycle
   always_comb begin
      next_readdata = avs_readdata_o;
      next_bus_state = bus_state;
      unique case (bus_state)
         BUS_IDLE: begin
            if (bus_req) begin
               next_bus_state = BUS_ACK;
               next_readdata = '0;
               if (avs_read_i) begin
                  unique case (avs_address_i)
                     OFS_CLK_SEL: next_readdata[7:0] = clk_sel;
                     OFS_TICK_CTRL: next_readdata[7:0] = tick_ctrl;
                     OFS_FLAGS: next_readdata[NUM_SRC-1:0] = flags;
                     OFS_ENABLES: next_readdata[NUM_SRC-1:0] = enables;
                     OFS_GLOBAL: next_readdata[GLB_EN_BIT] = glob_en;
                     OFS_STATUS: begin
                        next_readdata[3:0] = irq_vector_o;
                        next_readdata[ST_REQ_BIT] = irq_req_o;
                     end
                     default: next_readdata = '0;
                  endcase
               end
            end
         end
         BUS_ACK: begin
            next_bus_state = BUS_IDLE;
         end
         default: begin
            next_bus_state = BUS_IDLE;
         end
      endcase
   end

   // Bus state and read data register
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         bus_state <= BUS_IDLE;
         avs_readdata_o <= '0;
      end else begin
         bus_state <= next_bus_state;
         avs_readdata_o <= next_readdata;
      end
   end

   // Checks on the block's flags, enables, time bases and outputs
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   conv_flag_a: assert property (conv_done_i |=> flags[SRC_CONV]) // see RULE_01
      else $error("conversion done did not set its flag");
   req_gate_a: assert property (irq_req_o |-> // see RULE_02
      $past(glob_en) && !$past(stack_full_i) && |$past(pending))
      else $error("request raised without both enables");
   ack_clear_a: assert property (irq_ack_i && !return_from_irq_i |=> !glob_en) // see RULE_03
      else $error("service left global enable set");
   tick_flag_a: assert property (tick_ovf[1] |=> flags[SRC_TICK1]) // see RULE_04
      else $error("time base overflow did not set its flag");
   tick_period_a: assert property (tick_ovf[0] && tick_cfg[0] == 6'h20 // see RULE_08
      |-> ##FAST_PERIOD (tick_ovf[0] || tick_cfg[0] != 6'h20))
      else $error("time base period wrong");
   tick_off_a: assert property (!tick_cfg[0].on |=> g_tick[0].cnt == '0) // see RULE_07
      else $error("stopped time base still counting");
   sel_rsvd_a: assert property ((clk_sel & ~CS_MASK) == 8'h00) // see RULE_06
      else $error("reserved clock-select bits set");
   flag_hold_a: assert property (flags[SRC_CONV] && !wr_fire // see RULE_20
      && !(irq_ack_i && irq_vector_o == SRC_CONV) |=> flags[SRC_CONV])
      else $error("flag dropped without service");
   wake_rise_a: assert property ($rose(flags[SRC_EEPROM]) |=> wake_o) // see RULE_17
      else $error("flag rise did not wake");
   return_from_irq_set_a: assert property (return_from_irq_i |=> glob_en) // see RULE_21
      else $error("return did not restore global enable");
   stack_block_a: assert property (stack_full_i |=> !irq_req_o) // see RULE_22
      else $error("request raised with full stack");
   prio_pick_a: assert property (irq_req_o && $past(pending[SRC_TICK0]) // see RULE_23
      |-> irq_vector_o == SRC_TICK0)
      else $error("highest priority source not chosen");
   bus_answer_a: assert property (avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("bus wait longer than one cycle");

   ack_seen_c: cover property (irq_req_o ##1 irq_ack_i ##1 return_from_irq_i);
   tick_seen_c: cover property (tick_ovf[0] ##[1:FAST_PERIOD] tick_ovf[0]);
   wake_seen_c: cover property (wake_o && !glob_en);
   sport_seen_c: cover property (irq_ack_i && irq_vector_o == SRC_SPORT);
endmodule

// >>> verif/pitb_core_model.sv
// Core model: takes request vectors and returns from handlers.
// Assumes its controls change just after rising edges of clk_sys_i.
module pitb_core_model (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic en_i, // Accept requests
   input wire logic auto_ret_i, // Return as soon as taken
   input wire logic [3:0] lag_i, // Cycles to wait before taking
   input wire logic irq_req_i,
   output logic irq_ack_o,
   output logic return_from_irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_cnt; // Cycles waited
   // One ack per request after the lag, only while request high
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         irq_ack_o <= 1'b0;
         return_from_irq_o <= 1'b0;
         wait_cnt <= 4'h0;
      end else begin
         irq_ack_o <= 1'b0;
         return_from_irq_o <= irq_ack_o & auto_ret_i;
         if (irq_ack_o || !irq_req_i || !en_i) begin
            wait_cnt <= 4'h0;
         end else if (wait_cnt == lag_i) begin
            irq_ack_o <= 1'b1;
         end else begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end
   end
endmodule

// >>> verif/peripheral_irq_and_time_base_tb.sv
// Bench for the request and time-base block against a flag model.
// Assumes the package offsets and source order, and the core model beside it.
module peripheral_irq_and_time_base_tb import pitb_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic [4:0] avs_address_i = 5'h00;
   logic avs_read_i = 1'b0, avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
   logic avs_waitrequest_o, irq_ack_i, return_from_irq_i, irq_req_o, wake_o;
   logic conv_done_i = 1'b0, eeprom_write_done_i = 1'b0, touch_slot_ovf_i = 1'b0;
   logic [1:0] compact_timer_match_i = 2'h0;
   logic [3:0] periodic_timer_match_i = 4'h0, serial_iface_evt_i = 4'h0, irq_vector_o;
   logic [5:0] serial_port_cond_i = 6'h00;
   logic low_supply_async_i = 1'b0, sub_clk_i = 1'b0, hs_clk_i = 1'b0, stack_full_i = 1'b0;
   logic core_en = 1'b0, auto_ret = 1'b0;
   logic [3:0] lag = 4'h0; // Core delay before taking
   int errors = 0, n_tests = 0, cyc = 0, n_wake = 0;
   logic [13:0] exp_flags = 14'h0; // Model of the request flags
   logic [3:0] ack_vec[$]; // Vectors taken by the core
   int ack_time[$]; // Cycle of each take
   int cfg_tb[5] = '{0, 0, 1, 0, 1};
   int cfg_src[5] = '{0, 0, 1, 2, 3};
   int cfg_code[5] = '{0, 1, 0, 0, 0};

   pitb_top u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .conv_done_i(conv_done_i),
      .compact_timer_match_i(compact_timer_match_i),
      .periodic_timer_match_i(periodic_timer_match_i),
      .eeprom_write_done_i(eeprom_write_done_i), .touch_slot_ovf_i(touch_slot_ovf_i),
      .serial_iface_evt_i(serial_iface_evt_i), .serial_port_cond_i(serial_port_cond_i),
      .low_supply_async_i(low_supply_async_i), .sub_clk_i(sub_clk_i), .hs_clk_i(hs_clk_i),
      .stack_full_i(stack_full_i), .irq_ack_i(irq_ack_i),
      .return_from_irq_i(return_from_irq_i), .irq_req_o(irq_req_o),
      .irq_vector_o(irq_vector_o), .wake_o(wake_o));
   pitb_core_model u_core (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .en_i(core_en),
      .auto_ret_i(auto_ret), .lag_i(lag), .irq_req_i(irq_req_o), .irq_ack_o(irq_ack_i),
      .return_from_irq_o(return_from_irq_i));

   // System clock, 10 ns period
   initial begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // Slow clocks, wake count, service log and run limit
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      sub_clk_i <= cyc[2];
      hs_clk_i <= cyc[1];
      if (wake_o === 1'b1) begin
         n_wake <= n_wake + 1;
      end
      if (irq_ack_i === 1'b1) begin
         ack_vec.push_back(irq_vector_o);
         ack_time.push_back(cyc);
      end
      if (cyc > 60000) begin
         errors = errors + 1;
         report_and_stop();
      end
   end
   // Compare and count
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   // One Avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= w;
      avs_read_i <= ~w;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      chk("bus answer", 2, n);
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk($sformatf("reg %0h", a), e, q);
   endtask
   // Highest priority pending source in the model
   function automatic logic [3:0] lowest(input logic [13:0] f);
      lowest = 4'h0;
      for (int i = 13; i >= 0; i--) begin
         if (f[i]) lowest = 4'(i);
      end
   endfunction
   // Raise one source's event, then let it land in its flag
   task automatic pulse_src(input int s);
      @(posedge clk_sys_i);
      case (s)
         1: touch_slot_ovf_i <= 1'b1;
         2, 3: compact_timer_match_i[s-2] <= 1'b1;
         4, 5: periodic_timer_match_i[s-4] <= 1'b1;
         10, 11: periodic_timer_match_i[s-8] <= 1'b1;
         6: serial_port_cond_i[$urandom_range(5)] <= 1'b1;
         7: eeprom_write_done_i <= 1'b1;
         8: serial_iface_evt_i[$urandom_range(3)] <= 1'b1;
         12: conv_done_i <= 1'b1;
         default: low_supply_async_i <= 1'b1;
      endcase
      @(posedge clk_sys_i);
      {touch_slot_ovf_i, compact_timer_match_i, periodic_timer_match_i} <= 7'h00;
      {eeprom_write_done_i, serial_iface_evt_i, conv_done_i} <= 6'h00;
      repeat (8) @(posedge clk_sys_i);
      {serial_port_cond_i, low_supply_async_i} <= 7'h00;
      repeat (4) @(posedge clk_sys_i);
      exp_flags[s] = 1'b1;
   endtask
   // Wait, bounded, for k services
   task automatic wait_acks(input int k, input int lim);
      int n;
      n = 0;
      while (ack_vec.size() < k && n < lim) begin
         @(posedge clk_sys_i);
         n++;
      end
      chk("services", k, ack_vec.size());
   endtask

   initial begin
      int w, k, per, sh;
      void'($urandom(43623));
      repeat (5) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      // Reset values, masked bits and a hole in the map
      rd(OFS_CLK_SEL, 32'h0);
      rd(OFS_TICK_CTRL, 32'h0);
      rd(OFS_GLOBAL, 32'h0);
      wr(OFS_CLK_SEL, 32'hFF);
      rd(OFS_CLK_SEL, 32'h33);
      wr(OFS_TICK_CTRL, 32'h77);
      rd(OFS_TICK_CTRL, 32'h77);
      wr(5'h18, 32'hFF);
      rd(5'h18, 32'h0);
      wr(OFS_TICK_CTRL, 32'h0);
      wr(OFS_CLK_SEL, 32'h0);
      $display("test registers done");
      // Every event except the two time-base ticks sets its flag and wakes, with all enables off
      for (int s = 1; s < 14; s++) begin
         if (s != 9) begin
            w = n_wake;
            pulse_src(s);
            chk("wake", w + 1, n_wake);
            rd(OFS_FLAGS, 32'(exp_flags));
         end
      end
      w = n_wake;
      pulse_src(12);
      chk("preset flag wake", w, n_wake);
      chk("request disabled", 0, irq_req_o);
      wr(OFS_FLAGS, 32'h0);
      exp_flags = 14'h0;
      $display("test events done");
      // Random pending set, served lowest index first
      wr(OFS_ENABLES, 32'h3FFF);
      lag <= 4'($urandom_range(3));
      core_en <= 1'b1;
      auto_ret <= 1'b1;
      for (int s = 1; s < 14; s++) begin
         if (s != 9 && $urandom_range(1) == 1) pulse_src(s);
      end
      pulse_src(2);
      k = $countones(exp_flags);
      ack_vec.delete();
      wr(OFS_GLOBAL, 32'h1);
      wait_acks(k, 2000);
      while (ack_vec.size() > 0) begin
         chk("vector", lowest(exp_flags), ack_vec.pop_front());
         exp_flags[lowest(exp_flags)] = 1'b0;
      end
      rd(OFS_FLAGS, 32'h0);
      rd(OFS_GLOBAL, 32'h1);
      // Service with no return leaves global enable cleared
      auto_ret <= 1'b0;
      pulse_src(7);
      wait_acks(1, 50);
      chk("vector", SRC_EEPROM, ack_vec.pop_front());
      exp_flags = 14'h0;
      rd(OFS_GLOBAL, 32'h0);
      rd(OFS_FLAGS, 32'h0);
      // Full return stack holds the request back
      stack_full_i <= 1'b1;
      wr(OFS_GLOBAL, 32'h1);
      pulse_src(12);
      repeat (20) @(posedge clk_sys_i);
      chk("blocked services", 0, ack_vec.size());
      chk("request while full", 0, irq_req_o);
      stack_full_i <= 1'b0;
      wait_acks(1, 50);
      chk("vector", SRC_CONV, ack_vec.pop_front());
      exp_flags = 14'h0;
      $display("test service done");
      // Time bases: period per source and code, recurring
      auto_ret <= 1'b1;
      lag <= 4'h0;
      for (int i = 0; i < 5; i++) begin
         sh = cfg_tb[i] * 4;
         per = (1 << (8 + cfg_code[i])) * (cfg_src[i] == 0 ? 1 : cfg_src[i] == 2 ? 8 : 4);
         wr(OFS_TICK_CTRL, 32'h0);
         wr(OFS_FLAGS, 32'h0);
         wr(OFS_ENABLES, 32'h1 << (cfg_tb[i] * 9));
         wr(OFS_CLK_SEL, cfg_src[i] << sh);
         wr(OFS_GLOBAL, 32'h1);
         ack_vec.delete();
         ack_time.delete();
         wr(OFS_TICK_CTRL, (8 | cfg_code[i]) << sh);
         wait_acks(3, 3 * per + 200);
         chk("tick period", per, ack_time[2] - ack_time[1]);
         chk("tick period", per, ack_time[1] - ack_time[0]);
         chk("tick vector", cfg_tb[i] ? SRC_TICK1 : SRC_TICK0, ack_vec[2]);
      end
      wr(OFS_TICK_CTRL, 32'h0);
      rd(OFS_STATUS, 32'h9);
      $display("test time bases done");
      report_and_stop();
   end
   // Verdict and end of run
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
endmodule
